// [verilog/tmz_timer0.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tmz_map.svh"

// Contract
// R1 - Clock source bit clear: count one per instruction cycle without prescaler.
// R2 - A timer write blocks counting for the next two instruction cycles.
// R3 - Clock source bit set: count pin edges, edge bit picks rising or falling.
// R4 - Wrap from top to zero sets the overflow flag.
// R5 - Interrupt request only while overflow enable is set; mask leaves flag alone.
// R6 - Software clears the flag before re-enabling; hardware never clears it.
// R7 - Timer stops during sleep, so no overflow occurs in sleep.
// R8 - Wrap edge sets flag at once; register shows zero three oscillator periods later.
// R9 - Counter mode samples prescaler output or pin on phases two and four.
// R10 - External pin stays high and low at least two oscillator periods each.
// R11 - Prescaler divides the pin ahead of the phase sampling, symmetric output.
// R12 - One prescaler serves timer or watchdog; assignment bit clear means timer.
// R13 - Timer ratio choices run from 1:2 to 1:256 in powers of two.
// R14 - Prescaler count is neither readable nor loadable by software.
// R15 - Any timer write clears the prescaler while it serves the timer.
// R16 - Watchdog clear resets the prescaler while it serves the watchdog.
// R17 - Software follows the safe sequence when moving the prescaler to the watchdog.
// R18 - Timer keeps its value over every reset except power-on.
// R19 - Every reset loads all ones into the option register.
// R20 - Ratio select n gives division by two to the power n plus one; the watchdog scaled tick divides by two to the power n.
// R21 - Each synchronised edge gives exactly one increment.
module tmz_timer0 #(
  parameter int PRESC_W = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire tmz_pkg::tmz_bus_req_t bus_in,
  output logic [7:0] rdata_out,
  input wire logic sleep_in,
  input wire logic external_count_pin_in,
  input wire logic watchdog_tick_in,
  input wire logic watchdog_clear_instruction_in,
  output logic watchdog_scaled_tick_out,
  output logic overflow_irq_out,
  output logic [4:0] port_a_direction_out
);

  localparam int ROLL_CYC = (`TMZ_ROLL_TOSC * `TMZ_TOSC_NS + `TMZ_MCLK_NS - 1) / `TMZ_MCLK_NS;
  localparam int INH_CYC = (`TMZ_INHIBIT_TCY * `TMZ_TCY_TOSC * `TMZ_TOSC_NS + `TMZ_MCLK_NS - 1)
                           / `TMZ_MCLK_NS;

  initial begin
    if (PRESC_W != 8) begin
      $error("tmz_timer0: prescaler must be 8 bits wide");
    end
    if (ROLL_CYC < 1 || ROLL_CYC > 3 || INH_CYC > 15) begin
      $error("tmz_timer0: timing constants do not fit their counters");
    end
  end

  tmz_pkg::tmz_state_t st_ff;
  tmz_pkg::tmz_state_t nxt_st;

  logic cnt_mode;
  logic to_timer;
  logic [2:0] ratio;
  logic edge_fall;
  logic wr_count;
  logic pin_adj;
  logic presc_step;
  logic src_lvl;
  logic sample_now;
  logic inc_event;
  logic wrap_now;
  logic [7:0] wd_mask;

  always_comb begin
    cnt_mode = st_ff.option[`TMZ_OPT_CS];
    edge_fall = st_ff.option[`TMZ_OPT_SE];
    to_timer = ~st_ff.option[`TMZ_OPT_PSA];
    ratio = st_ff.option[`TMZ_OPT_RS_HI:`TMZ_OPT_RS_LO];
    wr_count = bus_in.wr && (bus_in.addr == `TMZ_ADDR_COUNT);
    wd_mask = 8'(((9'h001 << ratio) - 9'h001));
    nxt_st = st_ff;
    pin_adj = st_ff.pin_lvl;
    presc_step = 1'b0;
    src_lvl = 1'b0;
    sample_now = 1'b0;
    inc_event = 1'b0;
    wrap_now = 1'b0;

    // The pin is synchronised even in sleep so that no stale level is kept.
    nxt_st.sync = {st_ff.sync[1:0], external_count_pin_in};
    if (st_ff.sync[2] == st_ff.sync[1]) begin
      pin_adj = st_ff.sync[2] ^ edge_fall; // R3
    end
    nxt_st.pin_lvl = pin_adj;

    if (!sleep_in) begin // R7
      nxt_st.phase = st_ff.phase + 2'h1;

      // The shared divider steps on pin edges, instruction cycles or watchdog ticks.
      if (to_timer) begin // R12
        if (cnt_mode) begin
          presc_step = pin_adj && !st_ff.pin_lvl; // R11
        end else begin
          presc_step = (st_ff.phase == `TMZ_PH_Q1);
        end
      end else begin
        presc_step = watchdog_tick_in;
      end
      if (presc_step) begin
        nxt_st.presc = st_ff.presc + 8'h01;
      end

      // Bit n of the divider toggles at half the rate of bit n-1, so it is symmetric.
      if (to_timer) begin
        src_lvl = st_ff.presc[ratio]; // R13 R20
      end else if (cnt_mode) begin
        src_lvl = st_ff.pin_lvl;
      end else begin
        src_lvl = st_ff.phase[1]; // R1
      end

      sample_now = (st_ff.phase == `TMZ_PH_Q2) || (st_ff.phase == `TMZ_PH_Q4);
      if (sample_now) begin
        nxt_st.samp = src_lvl; // R9
        inc_event = src_lvl && !st_ff.samp; // R21
      end

      if (st_ff.inhibit != 4'h0) begin
        nxt_st.inhibit = st_ff.inhibit - 4'h1;
      end

      // The flag is set by the wrap edge itself; the visible count follows later.
      wrap_now = inc_event && (st_ff.inhibit == 4'h0) && (st_ff.count == `TMZ_COUNT_TOP);
      if (inc_event && st_ff.inhibit == 4'h0) begin // R2
        nxt_st.pend = 2'(ROLL_CYC);
        if (st_ff.count == `TMZ_COUNT_TOP) begin
          nxt_st.intctl[`TMZ_INT_OVF_FLAG] = 1'b1; // R4 R8
        end
      end
      if (st_ff.pend != 2'h0) begin
        nxt_st.pend = st_ff.pend - 2'h1;
        if (st_ff.pend == 2'h1) begin
          nxt_st.count = st_ff.count + 8'h01; // R8
        end
      end
    end

    if (!to_timer && watchdog_clear_instruction_in) begin
      nxt_st.presc = 8'h00; // R16
    end

    // Register writes; the divider has no address of its own.
    if (bus_in.wr) begin // R14
      if (bus_in.addr == `TMZ_ADDR_COUNT) begin
        nxt_st.count = bus_in.wdata;
        nxt_st.inhibit = 4'(INH_CYC); // R2
        nxt_st.pend = 2'h0;
        if (to_timer) begin
          nxt_st.presc = 8'h00; // R15
        end
      end else if (bus_in.addr == `TMZ_ADDR_INTCTL) begin
        // A wrap in the same cycle as a clearing write keeps the flag set.
        nxt_st.intctl = bus_in.wdata;
        nxt_st.intctl[`TMZ_INT_OVF_FLAG] = bus_in.wdata[`TMZ_INT_OVF_FLAG] | wrap_now; // R6
      end else if (bus_in.addr == `TMZ_ADDR_OPTION) begin
        nxt_st.option = bus_in.wdata;
      end else if (bus_in.addr == `TMZ_ADDR_PADIR) begin
        nxt_st.padir = bus_in.wdata[4:0];
      end
    end

    if (bus_in.rd) begin
      if (bus_in.addr == `TMZ_ADDR_COUNT) begin
        nxt_st.rdata = st_ff.count;
      end else if (bus_in.addr == `TMZ_ADDR_INTCTL) begin
        nxt_st.rdata = st_ff.intctl;
      end else if (bus_in.addr == `TMZ_ADDR_OPTION) begin
        nxt_st.rdata = st_ff.option;
      end else if (bus_in.addr == `TMZ_ADDR_PADIR) begin
        nxt_st.rdata = {3'h0, st_ff.padir};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end else begin
      nxt_st.rdata = 8'h00;
    end

    // A non power-on reset restores control state but leaves the count alone.
    if (soft_rst_in) begin
      nxt_st.option = `TMZ_OPTION_RESET; // R19
      nxt_st.intctl = `TMZ_INTCTL_RESET;
      nxt_st.padir = `TMZ_PADIR_RESET;
      nxt_st.presc = 8'h00;
      nxt_st.inhibit = 4'h0;
      nxt_st.pend = 2'h0;
      // Starting the sampler high means a changed edge polarity cannot fake an increment.
      nxt_st.samp = 1'b1;
      nxt_st.count = st_ff.count; // R18
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.option <= `TMZ_OPTION_RESET; // R19
      st_ff.intctl <= `TMZ_INTCTL_RESET;
      st_ff.padir <= `TMZ_PADIR_RESET;
      st_ff.count <= `TMZ_COUNT_POR; // R18
      // Falling edge is selected after reset, so an idle low pin reads as high here.
      st_ff.pin_lvl <= 1'b1;
      st_ff.samp <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;
  assign overflow_irq_out = st_ff.intctl[`TMZ_INT_OVF_FLAG] & st_ff.intctl[`TMZ_INT_OVF_EN]; // R5
  assign watchdog_scaled_tick_out = !to_timer && !sleep_in && watchdog_tick_in
                                    && ((st_ff.presc & wd_mask) == wd_mask); // R12
  assign port_a_direction_out = st_ff.padir;

endmodule
`default_nettype wire

// [include/tmz_map.svh]
`ifndef TMZ_MAP_SVH
`define TMZ_MAP_SVH

`define TMZ_ADDR_COUNT 8'h01
`define TMZ_ADDR_INTCTL 8'h0b
`define TMZ_ADDR_OPTION 8'h81
`define TMZ_ADDR_PADIR 8'h85

`define TMZ_OPT_CS 5
`define TMZ_OPT_SE 4
`define TMZ_OPT_PSA 3
`define TMZ_OPT_RS_HI 2
`define TMZ_OPT_RS_LO 0
`define TMZ_INT_OVF_EN 5
`define TMZ_INT_OVF_FLAG 2

`define TMZ_OPTION_RESET 8'hff
`define TMZ_INTCTL_RESET 8'h00
`define TMZ_PADIR_RESET 5'h1f
`define TMZ_COUNT_POR 8'h00
`define TMZ_COUNT_TOP 8'hff

`define TMZ_PH_Q1 2'h0
`define TMZ_PH_Q2 2'h1
`define TMZ_PH_Q4 2'h3

`define TMZ_MCLK_NS 25
`define TMZ_TOSC_NS 25
`define TMZ_ROLL_TOSC 3
`define TMZ_TCY_TOSC 4
`define TMZ_INHIBIT_TCY 2

`endif

// [include/tmz_pkg.sv]
package tmz_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmz_bus_req_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [2:0] sync;
    logic pin_lvl;
    logic [7:0] presc;
    logic samp;
    logic [3:0] inhibit;
    logic [1:0] pend;
    logic [7:0] count;
    logic [7:0] intctl;
    logic [7:0] option;
    logic [4:0] padir;
    logic [7:0] rdata;
  } tmz_state_t;

endpackage

// [testbench/tmz_timer0_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire tmz_pkg::tmz_bus_req_t bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic sleep_in,
  input wire logic external_count_pin_in,
  input wire logic watchdog_tick_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic watchdog_scaled_tick_out,
  input wire logic overflow_irq_out,
  input wire logic [4:0] port_a_direction_out
);
  logic [7:0] opt_ff;
  logic [3:0] since_ff;
  logic rdc, wrc, q;
  assign rdc = bus_in.rd && bus_in.addr == 8'h01;
  assign wrc = bus_in.wr && bus_in.addr == 8'h01;
  assign q = !bus_in.wr && !sleep_in && !soft_rst_in;
  // Shadow of the option register; the rate check must only run in plain timer mode.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      opt_ff <= 8'hff;
      since_ff <= 4'h0;
    end else begin
      since_ff <= wrc ? 4'h0 : since_ff + {3'h0, ~&since_ff};
      opt_ff <= soft_rst_in ? 8'hff : (bus_in.wr && bus_in.addr == 8'h81) ? bus_in.wdata : opt_ff;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  a_option_read: assert property (bus_in.rd && bus_in.addr == 8'h81 && !soft_rst_in
    |=> rdata_out == opt_ff) else $error("option read");
  a_unmapped_zero: assert property (bus_in.rd && !(bus_in.addr inside {8'h01, 8'h0b, 8'h81,
    8'h85}) |=> rdata_out == 8'h00) else $error("unmapped read");
  a_write_holds: assert property (wrc ##1 (!bus_in.wr)[*5] ##1 rdc
    |=> rdata_out == $past(bus_in.wdata, 7)) else $error("write hold");
  a_timer_rate: assert property (rdc && q && !opt_ff[5] && opt_ff[3] && since_ff > 4'hb
    ##1 q[*8] ##1 q[*3] ##1 rdc |=> rdata_out == $past(rdata_out, 12) + 8'h03) else $error("rate");
  a_mask_irq: assert property (bus_in.wr && bus_in.addr == 8'h0b && !bus_in.wdata[5]
    |=> !overflow_irq_out) else $error("mask");
  a_flag_sticky: assert property ($fell(overflow_irq_out) |->
    ($past(bus_in.wr) && $past(bus_in.addr) == 8'h0b) || $past(soft_rst_in)) else $error("sticky");
  a_sleep_noflag: assert property ($rose(overflow_irq_out) && !$past(bus_in.wr)
    |-> !($past(sleep_in) && $past(sleep_in, 2))) else $error("sleep flag");
  a_sleep_keep: assert property (sleep_in[*4] ##0 rdc ##1 (sleep_in && !bus_in.wr)[*3]
    ##0 (rdc && sleep_in) |=> rdata_out == $past(rdata_out, 3)) else $error("sleep count");
  cover property ($rose(overflow_irq_out));
  cover property (soft_rst_in && sleep_in);
  cover property (wrc);
endmodule
bind tmz_timer0 tmz_timer0_chk u_chk (.mclk_in, .rst_in, .soft_rst_in, .bus_in, .rdata_out,
  .sleep_in, .external_count_pin_in, .watchdog_tick_in, .watchdog_clear_instruction_in,
  .watchdog_scaled_tick_out, .overflow_irq_out, .port_a_direction_out);
`default_nettype wire

// [testbench/tmz_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Each level is held three clocks, one spare over the minimum the sampler needs.
module tmz_pin_src (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [7:0] pulses_in,
  output logic pin_out,
  output logic busy_out
);
  logic [8:0] left_ff;
  logic [1:0] hold_ff;
  assign busy_out = left_ff != 9'h000;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      left_ff <= 9'h000;
      hold_ff <= 2'h0;
      pin_out <= 1'b0;
    end else if (go_in) begin
      left_ff <= {pulses_in, 1'b0};
    end else if (busy_out) begin
      hold_ff <= (hold_ff == 2'h2) ? 2'h0 : hold_ff + 2'h1;
      if (hold_ff == 2'h2) begin
        pin_out <= ~pin_out;
        left_ff <= left_ff - 9'h001;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic soft_rst_in = 1'b0;
  logic sleep_in = 1'b0;
  logic go = 1'b0;
  logic busy, pin, irq;
  logic [7:0] npulse = 8'h00;
  logic wtick = 1'b0;
  logic wclr = 1'b0;
  logic wdo;
  logic [4:0] pdir;
  logic [7:0] rdata, v, a;
  tmz_pkg::tmz_bus_req_t bus_in = '0;
  int mismatches = 0;
  int comparisons = 0;
  tmz_timer0 DUT (.mclk_in, .rst_in, .soft_rst_in, .bus_in, .rdata_out(rdata), .sleep_in,
    .external_count_pin_in(pin), .watchdog_tick_in(wtick), .watchdog_clear_instruction_in(wclr),
    .watchdog_scaled_tick_out(wdo), .overflow_irq_out(irq), .port_a_direction_out(pdir));
  tmz_pin_src SRC (.mclk_in, .rst_in, .go_in(go), .pulses_in(npulse), .pin_out(pin),
    .busy_out(busy));
  initial forever #12.5 mclk_in = ~mclk_in;
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_in);
    bus_in <= '{ad, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk_in);
    bus_in <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in);
    bus_in.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [7:0] e, input string n);
    rd(ad);
    chk(n, e, v);
  endtask
  task automatic t_timer();
    wr(8'h81, 8'h08);
    wr(8'h0b, 8'h20);
    wr(8'h01, 8'hfd);
    repeat (4) @(posedge mclk_in);
    rc(8'h01, 8'hfd, "count");
    repeat (40) @(posedge mclk_in);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rd(8'h01);
    a = v;
    repeat (10) @(posedge mclk_in);
    rc(8'h01, a + 8'h03, "rate");
    wr(8'h0b, 8'h04);
    rc(8'h0b, 8'h04, "flag");
    chk("irq", 8'h00, {7'h00, irq});
    rc(8'h02, 8'h00, "unmapped");
  endtask
  task automatic t_count();
    logic [7:0] opt [5] = '{8'h20, 8'h21, 8'h22, 8'h28, 8'h38};
    logic [7:0] np [5] = '{8'h04, 8'h08, 8'h10, 8'h02, 8'h02};
    for (int n = 0; n < 5; n++) begin
      wr(8'h81, opt[n]);
      repeat (12) @(posedge mclk_in);
      wr(8'h01, 8'h00);
      @(posedge mclk_in);
      npulse <= np[n];
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      @(posedge mclk_in);
      repeat (1000) if (busy === 1'b1) @(posedge mclk_in);
      repeat (20) @(posedge mclk_in);
      rc(8'h01, 8'h02, "count");
    end
  endtask
  task automatic t_wdog();
    wr(8'h81, 8'h00);
    wr(8'h01, 8'h00);
    wclr <= 1'b1;
    @(posedge mclk_in);
    wclr <= 1'b0;
    wr(8'h81, 8'h0a);
    wclr <= 1'b1;
    @(posedge mclk_in);
    wclr <= 1'b0;
    wr(8'h85, 8'h15);
    rc(8'h85, 8'h15, "direction");
    chk("direction pins", 8'h15, {3'h0, pdir});
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_in);
      wtick <= 1'b1;
      #1 chk("scaled tick", {7'h00, k == 3}, {7'h00, wdo});
    end
    @(posedge mclk_in);
    wtick <= 1'b0;
  endtask
  task automatic t_sleep();
    wr(8'h81, 8'h08);
    sleep_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rd(8'h01);
    a = v;
    repeat (60) @(posedge mclk_in);
    rc(8'h01, a, "sleep");
    @(posedge mclk_in);
    rc(8'h01, a, "sleep again");
    soft_rst_in <= 1'b1;
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    rc(8'h01, a, "kept");
    rc(8'h81, 8'hff, "option");
    sleep_in <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    rc(8'h81, 8'hff, "option");
    t_timer();
    t_count();
    t_wdog();
    t_sleep();
    stop_test();
  end
  // Whole run is under two thousand clocks; the limit leaves ample margin.
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
